// file: pan_defines.svh
`ifndef PAN_DEFINES_SVH
`define PAN_DEFINES_SVH

// register indices within one port page; byte address is four times index
`define PAN_IDX_ID_LOW     12'h106
`define PAN_IDX_ADV        12'h108
`define PAN_IDX_PARTNER    12'h10A
`define PAN_IDX_EXPANSION  12'h10C
`define PAN_IDX_NEXT_PAGE  12'h10E

// port number sits above the per-port index
`define PAN_PORT_LSB       12
`define PAN_PORT_FIRST     3'h1

// advertisement field layout
`define PAN_ADV_WMASK      16'hADFF
`define PAN_ADV_RESET      16'h01E1
`define PAN_ADV_PAUSE_HI   11
`define PAN_ADV_PAUSE_LO   10
`define PAN_PAUSE_STRAP1   2'h3
`define PAN_PAUSE_STRAP0   2'h0

// partner ability layout
`define PAN_LP_NP_BIT      15
`define PAN_LP_ACK_BIT     14

// transmit next page layout
`define PAN_TNP_WMASK      16'hB7FF
`define PAN_TNP_RESET      16'h2001
`define PAN_TNP_TOGGLE_BIT 11

// expansion status layout
`define PAN_EXP_PDF_BIT    4
`define PAN_EXP_LPNP_BIT   3
`define PAN_EXP_NPA_BIT    2
`define PAN_EXP_PR_BIT     1
`define PAN_EXP_LPAN_BIT   0

// strap synchroniser fill time in cycles
`define PAN_SYNC_FILL      2'h3

`endif

// file: pan_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module pan_far_end
   import pan_pkg::*;
#(
   parameter int NPORT = 5
) (
   // clock
   input  wire logic                clk_i,
   // engine events toward the register set
   output var pan_eng_in_t [NPORT-1:0] eng_o
);
   // quiet line, no partner heard yet
   initial eng_o = '0;
   // one received base page; the word is scrambled once the pulse is gone
   task automatic send_base(input int p, input logic [15:0] w);
      @(posedge clk_i);
      eng_o[p].rx_word    <= w;
      eng_o[p].rx_base    <= 1'b1;
      eng_o[p].rx_page    <= 1'b1;
      eng_o[p].lp_an_able <= 1'b1;
      @(posedge clk_i);
      eng_o[p].rx_word <= ~w;
      eng_o[p].rx_base <= 1'b0;
      eng_o[p].rx_page <= 1'b0;
   endtask
   // parallel detection fault, or a sent word with its toggle
   task automatic send_flag(input int p, input bit fault, input logic tog);
      @(posedge clk_i);
      eng_o[p].pd_fault  <= fault;
      eng_o[p].tx_sent   <= !fault;
      eng_o[p].tx_toggle <= tog;
      @(posedge clk_i);
      eng_o[p].pd_fault <= 1'b0;
      eng_o[p].tx_sent  <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: pan_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "pan_defines.svh"

module pan_pin_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // pin and result
   input  wire logic pin_i,
   output logic      level_o,
   output logic      valid_o
);

   logic       s1_q;
   logic       s2_q;
   logic       s3_q;
   logic [1:0] fill_q;

   // three stage chain; only s2 and s3 are looked at
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once the last two stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_o <= s3_q;
      end
   end

   // valid once the chain holds real pin samples
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fill_q  <= 2'h0;
         valid_o <= 1'b0;
      end else begin
         if (fill_q != `PAN_SYNC_FILL) begin
            fill_q <= fill_q + 2'h1;
         end
         valid_o <= (fill_q == `PAN_SYNC_FILL) && (s2_q == s3_q);
      end
   end

endmodule

`default_nettype wire

// file: pan_pkg.sv
package pan_pkg;

   // register selected by one bus access
   typedef enum logic [4:0] {
      PAN_REG_ID  = 5'b00001,
      PAN_REG_ADV = 5'b00010,
      PAN_REG_LP  = 5'b00100,
      PAN_REG_EXP = 5'b01000,
      PAN_REG_TNP = 5'b10000
   } pan_reg_t;

   typedef struct packed {
      logic       hit;
      logic [2:0] port;
      pan_reg_t   kind;
   } pan_dec_t;

   // from the negotiation engine, one per port
   typedef struct packed {
      logic        rx_base;
      logic        rx_page;
      logic [15:0] rx_word;
      logic        lp_an_able;
      logic        pd_fault;
      logic        tx_sent;
      logic        tx_toggle;
   } pan_eng_in_t;

   // to the negotiation engine, one per port
   typedef struct packed {
      logic [15:0] adv;
      logic [15:0] tnp;
      logic        tnp_wr;
   } pan_eng_out_t;

endpackage

// file: pan_regs.sv
// How it works
// - each port has a read-only identifier low word; writes are ignored
// - advertisement bit 15 is writable next page capability, reset 0
// - advertisement bit 13 writable remote fault, reset 0; bits 14,12 read 0
// - advertisement bits 11:10 are a writable two-bit pause capability field
// - pause field default comes from the strap, sampled after reset release
// - advertisement bits 8 to 5 are writable ability flags, reset 1
// - advertisement bit 9 (T4) always reads 0
// - partner register mirrors received base page; bit 14 set once received
// - partner fields sit at the advertisement positions, bit 13 remote fault
// - expansion bit 4 latches a parallel detection fault until read
// - expansion bit 3 shows partner next page capability
// - expansion bit 2 always reads 1, local next page able
// - expansion bit 1 latches when a new page is received
// - expansion bit 0 shows partner negotiation able; bits 15:5 read 0
// - next page bit 15 writable, reset 0, 1 means more pages follow
// - next page bit 13 writable message page flag, reset 1; bit 14 reads 0
// - next page bit 12 writable acknowledge 2, reset 0
// - next page bit 11 read-only, shows last transmitted toggle, reset 0
`timescale 1ns/1ps
`default_nettype none
`include "pan_defines.svh"

module pan_regs
   import pan_pkg::*;
#(
   parameter int          NPORT      = 5,
   parameter int          AW         = 17,
   // arbitrary neutral identifier value
   parameter logic [15:0] PHY_IDENTIFIER_LOW = 16'h5A3C
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [AW-1:0]            wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   // configuration strap pin
   input  wire logic                     pause_default_strap_i,
   // negotiation engine side
   input  wire pan_eng_in_t  [NPORT-1:0] eng_i,
   output pan_eng_out_t      [NPORT-1:0] eng_o
);

   // address decode: port in the upper index bits, register below
   function automatic pan_dec_t pan_decode(input logic [AW-3:0] idx);
      pan_dec_t   d;
      logic [2:0] p;
      d.hit  = 1'b1;
      d.kind = PAN_REG_ID;
      p      = idx[`PAN_PORT_LSB +: 3];
      d.port = p - `PAN_PORT_FIRST;
      case (idx[`PAN_PORT_LSB-1:0])
         `PAN_IDX_ID_LOW:    d.kind = PAN_REG_ID;
         `PAN_IDX_ADV:       d.kind = PAN_REG_ADV;
         `PAN_IDX_PARTNER:   d.kind = PAN_REG_LP;
         `PAN_IDX_EXPANSION: d.kind = PAN_REG_EXP;
         `PAN_IDX_NEXT_PAGE: d.kind = PAN_REG_TNP;
         default:            d.hit  = 1'b0;
      endcase
      if (p < `PAN_PORT_FIRST || 32'(p) > NPORT) begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

   // byte-lane merge of a write into the writable bits
   function automatic logic [15:0] pan_merge(
      input logic [15:0] old,
      input logic [15:0] wdat,
      input logic [1:0]  sel,
      input logic [15:0] wmask
   );
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
      return (old & ~m) | (wdat & m);
   endfunction

   // per-port state
   logic [15:0] adv_q      [NPORT];
   logic [15:0] tnp_q      [NPORT];
   logic        toggle_q   [NPORT];
   logic [15:0] lp_q       [NPORT];
   logic        pdf_lh_q   [NPORT];
   logic        pr_lh_q    [NPORT];
   logic        tnp_wr_q   [NPORT];

   // bus and strap state
   logic        ack_q;
   logic [15:0] rdat_q;
   logic        loaded_q;
   logic        strap_lvl;
   logic        strap_ok;
   pan_dec_t    dec;
   logic        wr_go;
   logic        rd_go;

   pan_pin_sync u_strap (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (pause_default_strap_i),
      .level_o (strap_lvl),
      .valid_o (strap_ok)
   );

   assign dec = pan_decode(wb_adr_i[AW-1:2]);

   // a write lands on the edge where the master sees ack
   assign wr_go = ack_q && wb_we_i && dec.hit;
   // a read clears latches on the edge that snapshots them, so no event slips between snapshot and clear
   assign rd_go = wb_cyc_i && wb_stb_i && !ack_q && loaded_q && !wb_we_i && dec.hit;

   // strap is taken once, after the synchroniser has settled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loaded_q <= 1'b0;
      end else if (strap_ok) begin
         loaded_q <= 1'b1;
      end
   end

   // advertisement; only writable bits ever change, so reserved and T4 stay 0
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NPORT; i++) begin
         if (rst_i) begin
            adv_q[i] <= `PAN_ADV_RESET;
         end else if (strap_ok && !loaded_q) begin
            adv_q[i][`PAN_ADV_PAUSE_HI:`PAN_ADV_PAUSE_LO] <=
               strap_lvl ? `PAN_PAUSE_STRAP1 : `PAN_PAUSE_STRAP0;
         end else if (wr_go && dec.kind == PAN_REG_ADV && 32'(dec.port) == i) begin
            adv_q[i] <= pan_merge(adv_q[i], wb_dat_i[15:0],
                                  wb_sel_i[1:0], `PAN_ADV_WMASK);
         end
      end
   end

   // transmit next page; toggle is kept apart and is never written
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NPORT; i++) begin
         if (rst_i) begin
            tnp_q[i]    <= `PAN_TNP_RESET;
            tnp_wr_q[i] <= 1'b0;
         end else begin
            tnp_wr_q[i] <= 1'b0;
            if (wr_go && dec.kind == PAN_REG_TNP && 32'(dec.port) == i) begin
               tnp_q[i]    <= pan_merge(tnp_q[i], wb_dat_i[15:0],
                                        wb_sel_i[1:0], `PAN_TNP_WMASK);
               tnp_wr_q[i] <= 1'b1;
            end
         end
      end
   end

   // toggle follows each link code word the engine sends
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NPORT; i++) begin
         if (rst_i) begin
            toggle_q[i] <= 1'b0;
         end else if (eng_i[i].tx_sent) begin
            toggle_q[i] <= eng_i[i].tx_toggle;
         end
      end
   end

   // partner base page mirror, acknowledge forced once a word arrived
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NPORT; i++) begin
         if (rst_i) begin
            lp_q[i] <= 16'h0000;
         end else if (eng_i[i].rx_base) begin
            lp_q[i] <= eng_i[i].rx_word;
            lp_q[i][`PAN_LP_ACK_BIT] <= 1'b1;
         end
      end
   end

   // latched events; a new event in the read cycle wins over the clear
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NPORT; i++) begin
         if (rst_i) begin
            pdf_lh_q[i] <= 1'b0;
            pr_lh_q[i]  <= 1'b0;
         end else begin
            pdf_lh_q[i] <= eng_i[i].pd_fault ||
                           (pdf_lh_q[i] && !(rd_go && dec.kind == PAN_REG_EXP
                                             && 32'(dec.port) == i));
            pr_lh_q[i]  <= eng_i[i].rx_page ||
                           (pr_lh_q[i] && !(rd_go && dec.kind == PAN_REG_EXP
                                            && 32'(dec.port) == i));
         end
      end
   end

   // read data for the decoded register of one port
   function automatic logic [15:0] pan_read(input pan_dec_t d);
      logic [15:0] r;
      logic [2:0]  p;
      r = 16'h0000;
      p = d.port;
      if (d.hit) begin
         case (d.kind)
            PAN_REG_ID:  r = PHY_IDENTIFIER_LOW;
            PAN_REG_ADV: r = adv_q[p];
            PAN_REG_LP:  r = lp_q[p];
            PAN_REG_EXP: begin
               r[`PAN_EXP_PDF_BIT]  = pdf_lh_q[p];
               r[`PAN_EXP_LPNP_BIT] = lp_q[p][`PAN_LP_NP_BIT];
               r[`PAN_EXP_NPA_BIT]  = 1'b1;
               r[`PAN_EXP_PR_BIT]   = pr_lh_q[p];
               r[`PAN_EXP_LPAN_BIT] = eng_i[p].lp_an_able;
            end
            PAN_REG_TNP: begin
               r = tnp_q[p];
               r[`PAN_TNP_TOGGLE_BIT] = toggle_q[p];
            end
            default:     r = 16'h0000;
         endcase
      end
      return r;
   endfunction

   // one wait state; requests stall until the strap has been taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q && loaded_q;
      end
   end

   // read data captured with the ack, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 16'h0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         rdat_q <= pan_read(dec);
      end
   end

   assign wb_ack_o = ack_q && wb_cyc_i && wb_stb_i;
   assign wb_dat_o = {16'h0000, rdat_q};

   // engine view of the software-owned words
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         eng_o[i].adv    = adv_q[i];
         eng_o[i].tnp    = tnp_q[i];
         eng_o[i].tnp[`PAN_TNP_TOGGLE_BIT] = toggle_q[i];
         eng_o[i].tnp_wr = tnp_wr_q[i];
      end
   end

endmodule

`default_nettype wire

// file: pan_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pan_regs_monitor
   import pan_pkg::*;
#(
   parameter int          NPORT      = 5,
   parameter int          AW         = 17,
   parameter logic [15:0] PHY_IDENTIFIER_LOW = 16'h5A3C
) (
   // clock and reset
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   // bus
   input wire logic                     wb_cyc_i,
   input wire logic                     wb_stb_i,
   input wire logic                     wb_we_i,
   input wire logic [AW-1:0]            wb_adr_i,
   input wire logic [31:0]              wb_dat_o,
   input wire logic                     wb_ack_o,
   // engine side
   input wire pan_eng_in_t  [NPORT-1:0] eng_i,
   input wire pan_eng_out_t [NPORT-1:0] eng_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a pending request; the strap load may stall it for a few cycles
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_ack_bounded: assert property (s_req |-> ##[1:12] wb_ack_o)
      else $error("request never acknowledged");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_gated: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   // per-port fixed bits and engine-driven fields
   for (genvar g = 0; g < NPORT; g++) begin : g_port
      a_adv_fixed_zero: assert property (eng_o[g].adv[14] == 1'b0 && eng_o[g].adv[12] == 1'b0 && eng_o[g].adv[9] == 1'b0)
         else $error("advertisement fixed bit set");
      a_tnp_reserved: assert property (eng_o[g].tnp[14] == 1'b0)
         else $error("next page reserved bit set");
      a_toggle_follow: assert property (eng_i[g].tx_sent |=> eng_o[g].tnp[11] == $past(eng_i[g].tx_toggle))
         else $error("toggle not following sent word");
      a_reset_values: assert property ($fell(rst_i) |-> eng_o[g].adv == 16'h01E1 && eng_o[g].tnp == 16'h2001)
         else $error("register reset value wrong");
      a_exp_fixed: assert property (wb_ack_o && !wb_we_i && wb_adr_i[16:2] == {3'(g + 1), 12'h10C} |-> wb_dat_o[15:5] == 11'h000 && wb_dat_o[2])
         else $error("expansion fixed bits wrong");
      a_id_const: assert property (wb_ack_o && !wb_we_i && wb_adr_i[16:2] == {3'(g + 1), 12'h106} |-> wb_dat_o[15:0] == PHY_IDENTIFIER_LOW)
         else $error("identifier word wrong");
      a_tnp_wr_pulse: assert property (wb_ack_o && wb_we_i && wb_adr_i[16:2] == {3'(g + 1), 12'h10E} |=> eng_o[g].tnp_wr)
         else $error("next page write not flagged to engine");
   end
endmodule
bind pan_regs pan_regs_monitor #(.NPORT(NPORT), .AW(AW), .PHY_IDENTIFIER_LOW(PHY_IDENTIFIER_LOW)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .eng_i(eng_i), .eng_o(eng_o));
`default_nettype wire

// file: test_phy_autoneg_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_autoneg_register_set;
   import pan_pkg::*;
   // arbitrary identifier value
   localparam logic [15:0] ID_LOW = 16'h5A3C;
   logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, strap;
   logic [16:0]         wb_adr_i;
   logic [3:0]          wb_sel_i;
   logic [31:0]         wb_dat_i, wb_dat_o;
   logic [15:0]         rd;
   pan_eng_in_t  [4:0]  eng_i;
   pan_eng_out_t [4:0]  eng_o;
   int                  n_fail = 0;
   int                  comparisons = 0;
   pan_regs #(.NPORT(5), .AW(17), .PHY_IDENTIFIER_LOW(ID_LOW)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pause_default_strap_i(strap), .eng_i(eng_i), .eng_o(eng_o));
   pan_far_end #(.NPORT(5)) FAR (.clk_i(clk_i), .eng_o(eng_i));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle; the leading edge leaves cyc low for a cycle between calls
   task automatic bus(input logic we, input int p, input logic [11:0] idx, input logic [3:0] sel,
                      input logic [15:0] wd, output logic [15:0] rdata);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {3'(p), idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {16'h0000, wd};
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 40) begin
         n_fail++;
         $display("[FAIL] %0t no ack", $time);
         report_and_stop();
      end
      rdata = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input int p, input logic [11:0] idx, input logic [15:0] d);
      bus(1'b1, p, idx, 4'h3, d, rd);
   endtask
   task automatic rd_chk(input int p, input logic [11:0] idx, input logic [15:0] exp);
      bus(1'b0, p, idx, 4'h3, 16'h0000, rd);
      check(rd, exp);
   endtask
   // every port after reset, strap high
   task automatic t_defaults();
      for (int p = 1; p <= 5; p++) begin
         rd_chk(p, 12'h106, ID_LOW);
         rd_chk(p, 12'h108, 16'h0DE1);
         rd_chk(p, 12'h10A, 16'h0000);
         rd_chk(p, 12'h10C, 16'h0004);
         rd_chk(p, 12'h10E, 16'h2001);
      end
   endtask
   // writable masks, pause codes, byte lane, unmapped places
   task automatic t_writes();
      wr(2, 12'h106, 16'hFFFF);
      rd_chk(2, 12'h106, ID_LOW);
      wr(2, 12'h108, 16'hFFFF);
      rd_chk(2, 12'h108, 16'hADFF);
      check(eng_o[1].adv, 16'hADFF);
      for (int c = 0; c < 4; c++) begin
         wr(2, 12'h108, 16'(c << 10));
         rd_chk(2, 12'h108, 16'(c << 10));
      end
      bus(1'b1, 2, 12'h108, 4'h1, 16'hFFFF, rd);
      rd_chk(2, 12'h108, 16'h0CFF);
      wr(2, 12'h10E, 16'hFFFF);
      rd_chk(2, 12'h10E, 16'hB7FF);
      wr(2, 12'h10E, 16'h0000);
      rd_chk(2, 12'h10E, 16'h0000);
      wr(0, 12'h108, 16'h0000);
      rd_chk(0, 12'h108, 16'h0000);
      rd_chk(6, 12'h108, 16'h0000);
      rd_chk(1, 12'h100, 16'h0000);
      rd_chk(1, 12'h108, 16'h0DE1);
   endtask
   // partner pages, latched events and their clearing read
   task automatic t_partner();
      FAR.send_base(3, 16'hE5E1);
      rd_chk(4, 12'h10A, 16'hE5E1);
      rd_chk(4, 12'h10C, 16'h000F);
      rd_chk(4, 12'h10C, 16'h000D);
      FAR.send_flag(3, 1'b1, 1'b0);
      rd_chk(4, 12'h10C, 16'h001D);
      rd_chk(4, 12'h10C, 16'h000D);
      FAR.send_base(3, 16'h4001);
      rd_chk(4, 12'h10A, 16'h4001);
      rd_chk(4, 12'h10C, 16'h0007);
   endtask
   // toggle of the last sent word
   task automatic t_toggle();
      FAR.send_flag(4, 1'b0, 1'b1);
      rd_chk(5, 12'h10E, 16'h2801);
      check(eng_o[4].tnp, 16'h2801);
      FAR.send_flag(4, 1'b0, 1'b0);
      rd_chk(5, 12'h10E, 16'h2001);
   endtask
   // second reset with the strap low
   task automatic t_strap_low();
      strap <= 1'b0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(1, 12'h108, 16'h01E1);
   endtask
   // main sequence
   initial begin
      rst_i    = 1'b1;
      strap    = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 17'h00000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_defaults();
      t_writes();
      t_partner();
      t_toggle();
      t_strap_low();
      report_and_stop();
   end
endmodule
`default_nettype wire
